// ==== hdl/rsl_consts.svh ====
// Constants shared by both ends of the radio serial link.
// Included by bare name; holds definitions only.
`ifndef RSL_CONSTS_SVH
`define RSL_CONSTS_SVH

`define RSL_SYS_CLK_NS       4
`define RSL_PORT_MIN_BIT_NS  80
`define RSL_RADIO_MIN_BIT_NS 100
`define RSL_BYTE_W           8
`define RSL_BIT_CNT_W        3
`define RSL_HALF_IDX_W       4
`define RSL_LAST_HALF        4'hf
`define RSL_LAST_BIT         3'h7
`define RSL_ADDR_W           7
`define RSL_REG_COUNT        128
`define RSL_FLAG_N           4
`define RSL_FLAG_DONE        0
`define RSL_FLAG_WCOL        1
`define RSL_FLAG_MODF        2
`define RSL_FLAG_OVR         3
`define RSL_FLAGS_RESET      4'h0
`define RSL_BYTE_RESET       8'h00
`define RSL_ADDR_RESET       7'h00

`endif

// ==== hdl/rsl_pkg.sv ====
// Types shared by both ends of the radio serial link.
// No assumptions beyond a SystemVerilog compiler.
package rsl_pkg;
  typedef enum logic { MST_IDLE, MST_SHIFT } rsl_mst_state_t;
  typedef enum logic [1:0] { RAD_IDLE, RAD_ADDR, RAD_DATA } rsl_rad_state_t;
endpackage : rsl_pkg

// ==== hdl/rsl_if.sv ====
// Four-wire link between the host serial port and the radio slave.
// The radio output is weakly pulled high when nobody drives it.
`timescale 1ns/100ps
interface rsl_if;
  logic sck;
  logic mosi;
  logic nss_n;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // Pull-up wins when the radio releases its output
  assign miso = miso_oe ? miso_o : 1'b1;

  modport host  (output sck, output mosi, output nss_n, input miso);
  modport radio (input sck, input mosi, input nss_n,
                 output miso_o, output miso_oe);
endinterface : rsl_if

// ==== hdl/rsl_buf2.sv ====
// Two-entry valid/ready buffer, output straight from flip-flops.
// Same clock on both sides; in_ready falls only when both entries hold.
`timescale 1ns/100ps
module rsl_buf2 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output wire logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output wire logic         out_valid,
  input  wire logic         out_ready,
  output wire logic [W-1:0] out_data
);
  logic [W-1:0] head_r;
  logic [W-1:0] tail_r;
  logic         head_v_r;
  logic         tail_v_r;

  // Handshake decode
  wire push = in_valid & in_ready;
  wire pop  = head_v_r & out_ready;
  assign in_ready  = ~tail_v_r;
  assign out_valid = head_v_r;
  assign out_data  = head_r;

  // Head always holds the oldest word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_r   <= '0;
      tail_r   <= '0;
      head_v_r <= 1'b0;
      tail_v_r <= 1'b0;
    end else if (pop && push) begin
      head_r <= in_data;
    end else if (pop) begin
      head_r   <= tail_r;
      head_v_r <= tail_v_r;
      tail_v_r <= 1'b0;
    end else if (push && !head_v_r) begin
      head_r   <= in_data;
      head_v_r <= 1'b1;
    end else if (push) begin
      tail_r   <= in_data;
      tail_v_r <= 1'b1;
    end
  end
endmodule : rsl_buf2

// ==== hdl/rsl_host.sv ====
// Host serial port that talks to the radio slave over rsl_if.
// Assumes one 250 MHz clock; the radio output is a foreign pin.
// Summary of operation
// [R1] Master enable bit turns the port master
// [R2] Data write loads buffer, feeds idle shifter
// [R3] Outgoing line driven MSB first from shifter
// [R4] Byte end sets done flag, may interrupt
// [R5] Incoming bits shift in, byte to receive buffer
// [R6] Incoming pin ignored while port disabled
// [R7] Chip select comes from a software pin
// [R8] Transaction is select, address, data: 16 bits
// [R9] Select one writes, select zero reads
// [R10] Address picks one of 128 radio registers
// [R11] Radio latches a field every eighth clock
// [R12] Serial clock never above 10 MHz
// [R13] Radio reads ignore input, shift out register
// [R14] Radio output holds last bit, then pulled high
// [R15] Held select continues with next address
// [R16] Write to full buffer dropped, collision flag
// [R17] Select pulled low in multi-master: fault
// [R18] Full receive buffer keeps old, flags overrun
// [R19] Four flags interrupt, cleared by software
// [R20] Software sets phase and polarity to zero
// [R21] Rate register sets clock, capped 12.5 MHz
// [R22] Polarity sets idle level, phase edge
// [R23] Input sampled one clock before bit end
// [R24] Select stays low across whole transaction
`timescale 1ns/100ps
`include "rsl_consts.svh"
module rsl_host #(
  parameter int RATE_W = 8
) (
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  input  wire logic                  CTRL_WR,
  input  wire logic                  CTRL_MASTER_EN,
  input  wire logic                  CTRL_PORT_EN,
  input  wire logic                  CLK_PHASE,
  input  wire logic                  CLK_POL,
  input  wire logic [RATE_W-1:0]     CLK_RATE,
  input  wire logic                  INT_EN,
  input  wire logic                  MULTI_MASTER,
  input  wire logic                  SLAVE_SEL_N,
  input  wire logic                  CHIP_SELECT_N,
  input  wire logic                  TX_WRITE,
  input  wire logic [`RSL_BYTE_W-1:0] TX_DATA,
  input  wire logic                  RX_READ,
  output wire logic                  RX_VALID,
  output wire logic [`RSL_BYTE_W-1:0] RX_DATA,
  input  wire logic [`RSL_FLAG_N-1:0] FLAG_CLR,
  output logic      [`RSL_FLAG_N-1:0] FLAGS,
  output logic                       IRQ,
  output logic                       BUSY,
  output logic                       TX_EMPTY,
  output logic                       MASTER_EN,
  output logic                       PORT_EN,
  rsl_if.host                        LINK
);
  // Half period floor honours both the radio and the port limits
  localparam int MAX_BIT_NS = (`RSL_RADIO_MIN_BIT_NS > `RSL_PORT_MIN_BIT_NS)
                            ? `RSL_RADIO_MIN_BIT_NS : `RSL_PORT_MIN_BIT_NS;
  localparam int MIN_HALF = (MAX_BIT_NS / 2 + `RSL_SYS_CLK_NS - 1)
                            / `RSL_SYS_CLK_NS;
  localparam logic [RATE_W:0] MIN_HALF_V = (RATE_W+1)'(MIN_HALF);

  rsl_pkg::rsl_mst_state_t state_r, state_nxt;
  logic [RATE_W:0]             hcnt_r, hcnt_nxt;
  logic [`RSL_HALF_IDX_W-1:0]  idx_r, idx_nxt;
  logic [`RSL_BYTE_W-1:0]      shift_r, shift_nxt;
  logic [`RSL_BYTE_W-1:0]      tx_buf_r;
  logic                        tx_full_r;
  logic                        sck_r;
  logic                        mosi_r;
  logic                        nss_r;
  logic                        miso_m_r, miso_s_r;
  logic                        ssel_m_r, ssel_s_r;
  logic [`RSL_FLAG_N-1:0]      flag_set;

  // Decode of the running transfer
  wire busy      = (state_r == rsl_pkg::MST_SHIFT);
  wire [RATE_W:0] rate_half = {1'b0, CLK_RATE} + 1'b1;
  wire [RATE_W:0] half_len  = (rate_half < MIN_HALF_V)
                              ? MIN_HALF_V : rate_half; // R21 R12
  wire half_end  = busy && (hcnt_r == half_len - 1'b1);
  wire sample_now = half_end && idx_r[0]; // R23
  wire byte_end  = sample_now && (idx_r == `RSL_LAST_HALF);
  wire miso_bit  = miso_s_r & PORT_EN; // R6
  wire [`RSL_BYTE_W-1:0] rx_byte = {shift_r[`RSL_BYTE_W-2:0], miso_bit};
  wire start     = !busy && tx_full_r && MASTER_EN && PORT_EN; // R1 R2
  wire wr_ok     = TX_WRITE && !tx_full_r;
  wire wr_coll   = TX_WRITE && tx_full_r; // R16
  wire rx_ready;
  wire mode_fault = MASTER_EN && MULTI_MASTER && !ssel_s_r; // R17

  // Sticky event sources
  assign flag_set[`RSL_FLAG_DONE] = byte_end; // R4
  assign flag_set[`RSL_FLAG_WCOL] = wr_coll;
  assign flag_set[`RSL_FLAG_MODF] = mode_fault;
  assign flag_set[`RSL_FLAG_OVR]  = byte_end && !rx_ready; // R18

  // Link pins come straight from flip-flops
  assign LINK.sck   = sck_r;
  assign LINK.mosi  = mosi_r;
  assign LINK.nss_n = nss_r;

  // Next state of the shifter and bit timer
  always_comb begin
    state_nxt = state_r;
    hcnt_nxt  = hcnt_r;
    idx_nxt   = idx_r;
    shift_nxt = shift_r;
    case (state_r)
      rsl_pkg::MST_IDLE: begin
        if (start) begin
          state_nxt = rsl_pkg::MST_SHIFT;
          hcnt_nxt  = '0;
          idx_nxt   = '0;
          shift_nxt = tx_buf_r; // R2
        end
      end
      rsl_pkg::MST_SHIFT: begin
        if (half_end) begin
          hcnt_nxt = '0;
          idx_nxt  = idx_r + 1'b1;
          if (idx_r[0]) begin
            shift_nxt = rx_byte; // R5
          end
          if (byte_end) begin
            state_nxt = rsl_pkg::MST_IDLE;
          end
        end else begin
          hcnt_nxt = hcnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt = rsl_pkg::MST_IDLE;
      end
    endcase
    // Disabling the port abandons a byte in flight
    if (!PORT_EN) begin
      state_nxt = rsl_pkg::MST_IDLE;
    end
  end

  // Shifter registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= rsl_pkg::MST_IDLE;
      hcnt_r  <= '0;
      idx_r   <= '0;
      shift_r <= `RSL_BYTE_RESET;
    end else begin
      state_r <= state_nxt;
      hcnt_r  <= hcnt_nxt;
      idx_r   <= idx_nxt;
      shift_r <= shift_nxt;
    end
  end

  // Pin drive: even halves idle-level for phase 0, odd for phase 1
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_r  <= 1'b0;
      mosi_r <= 1'b0;
      nss_r  <= 1'b1;
    end else begin
      sck_r  <= CLK_POL ^ ((state_nxt == rsl_pkg::MST_SHIFT)
                && (idx_nxt[0] ^ CLK_PHASE)); // R22
      mosi_r <= shift_nxt[`RSL_BYTE_W-1]; // R3
      nss_r  <= CHIP_SELECT_N; // R7 R24
    end
  end

  // Foreign pins pass two flops before use
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      miso_m_r <= 1'b1;
      miso_s_r <= 1'b1;
      ssel_m_r <= 1'b1;
      ssel_s_r <= 1'b1;
    end else begin
      miso_m_r <= LINK.miso;
      miso_s_r <= miso_m_r;
      ssel_m_r <= SLAVE_SEL_N;
      ssel_s_r <= ssel_m_r;
    end
  end

  // Transmit buffer; a write while full never touches it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_buf_r  <= `RSL_BYTE_RESET;
      tx_full_r <= 1'b0;
    end else if (wr_ok) begin
      tx_buf_r  <= TX_DATA; // R16
      tx_full_r <= 1'b1;
    end else if (start) begin
      tx_full_r <= 1'b0;
    end
  end

  // Enables; a mode fault releases the bus and wins over a write
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MASTER_EN <= 1'b0;
      PORT_EN   <= 1'b0;
    end else if (mode_fault) begin
      MASTER_EN <= 1'b0; // R17
      PORT_EN   <= 1'b0;
    end else if (CTRL_WR) begin
      MASTER_EN <= CTRL_MASTER_EN; // R1
      PORT_EN   <= CTRL_PORT_EN;
    end
  end

  // Flags: a set in the clearing cycle survives
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FLAGS    <= `RSL_FLAGS_RESET;
      IRQ      <= 1'b0;
      BUSY     <= 1'b0;
      TX_EMPTY <= 1'b1;
    end else begin
      FLAGS    <= (FLAGS & ~FLAG_CLR) | flag_set; // R19
      IRQ      <= INT_EN && |((FLAGS & ~FLAG_CLR) | flag_set); // R4 R19
      BUSY     <= (state_nxt == rsl_pkg::MST_SHIFT);
      TX_EMPTY <= !(wr_ok || (tx_full_r && !start));
    end
  end

  // Received bytes wait here; software reads pair them into frames
  rsl_buf2 #(
    .W (`RSL_BYTE_W)
  ) u_rx_buf (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (byte_end), // R5 R8
    .in_ready  (rx_ready),
    .in_data   (rx_byte),
    .out_valid (RX_VALID),
    .out_ready (RX_READ),
    .out_data  (RX_DATA)
  );
endmodule : rsl_host

// ==== hdl/rsl_radio.sv ====
// Radio slave end: 128 byte registers behind a 16-bit serial frame.
// Link pins are foreign and pass two flops; mode is polarity 0, phase 0.
`timescale 1ns/100ps
`include "rsl_consts.svh"
module rsl_radio (
  input  wire logic                   CLK,
  input  wire logic                   RST_N,
  input  wire logic [`RSL_ADDR_W-1:0] REG_RD_ADDR,
  output logic      [`RSL_BYTE_W-1:0] REG_RD_DATA,
  output logic                        WR_PULSE,
  output logic      [`RSL_ADDR_W-1:0] WR_ADDR,
  output logic      [`RSL_BYTE_W-1:0] WR_DATA,
  rsl_if.radio                        LINK
);
  rsl_pkg::rsl_rad_state_t state_r;
  logic [`RSL_BYTE_W-1:0]   mem [`RSL_REG_COUNT];
  logic [2:0]               sck_p_r;
  logic [1:0]               mosi_p_r;
  logic [1:0]               nss_p_r;
  logic [`RSL_BIT_CNT_W-1:0] cnt_r;
  logic [`RSL_BYTE_W-1:0]   in_sh_r;
  logic [`RSL_BYTE_W-1:0]   out_sh_r;
  logic [`RSL_ADDR_W-1:0]   addr_r;
  logic                     write_r;
  logic                     miso_r;
  logic                     oe_r;

  // Edge and field decode on synchronised pins
  wire rise    = sck_p_r[1] & ~sck_p_r[2];
  wire fall    = ~sck_p_r[1] & sck_p_r[2];
  wire sel     = ~nss_p_r[1];
  wire [`RSL_BYTE_W-1:0] byte_in = {in_sh_r[`RSL_BYTE_W-2:0], mosi_p_r[1]};
  wire last    = rise && (cnt_r == `RSL_LAST_BIT); // R11
  wire in_data = (state_r == rsl_pkg::RAD_DATA);
  wire [`RSL_ADDR_W-1:0] hdr_addr = byte_in[`RSL_ADDR_W-1:0]; // R10
  wire [`RSL_ADDR_W-1:0] next_addr = addr_r + 1'b1; // R15
  wire do_write = last && in_data && write_r; // R9 R13

  assign LINK.miso_o  = miso_r;
  assign LINK.miso_oe = oe_r;

  // Pin synchronisers; the third sck stage is for edge finding
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_p_r  <= '0;
      mosi_p_r <= '0;
      nss_p_r  <= 2'h3;
    end else begin
      sck_p_r  <= {sck_p_r[1:0], LINK.sck};
      mosi_p_r <= {mosi_p_r[0], LINK.mosi};
      nss_p_r  <= {nss_p_r[0], LINK.nss_n};
    end
  end

  // Frame: select bit and address, then data bytes while selected
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r  <= rsl_pkg::RAD_IDLE;
      cnt_r    <= '0;
      in_sh_r  <= `RSL_BYTE_RESET;
      out_sh_r <= `RSL_BYTE_RESET;
      addr_r   <= `RSL_ADDR_RESET;
      write_r  <= 1'b0;
    end else begin
      case (state_r)
        rsl_pkg::RAD_IDLE: begin
          cnt_r <= '0;
          if (sel) begin
            state_r <= rsl_pkg::RAD_ADDR;
          end
        end
        rsl_pkg::RAD_ADDR, rsl_pkg::RAD_DATA: begin
          if (rise) begin
            in_sh_r <= byte_in;
            cnt_r   <= cnt_r + 1'b1;
          end
          if (last && !in_data) begin
            write_r  <= byte_in[`RSL_BYTE_W-1]; // R8 R9
            addr_r   <= hdr_addr;
            out_sh_r <= mem[hdr_addr]; // R13
            state_r  <= rsl_pkg::RAD_DATA;
          end else if (last) begin
            addr_r   <= next_addr; // R15
            out_sh_r <= mem[next_addr];
          end else if (fall && in_data && !write_r) begin
            out_sh_r <= {out_sh_r[`RSL_BYTE_W-2:0], 1'b0};
          end
          if (!sel) begin
            state_r <= rsl_pkg::RAD_IDLE;
          end
        end
        default: begin
          state_r <= rsl_pkg::RAD_IDLE;
        end
      endcase
    end
  end

  // Output holds the last bit; released when select rises
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      miso_r <= 1'b1;
      oe_r   <= 1'b0;
    end else begin
      oe_r <= sel; // R14
      if (fall && in_data && !write_r && sel) begin
        miso_r <= out_sh_r[`RSL_BYTE_W-1]; // R13 R14
      end
    end
  end

  // Register array, no reset: contents are data, not control
  always_ff @(posedge CLK) begin
    if (do_write) begin
      mem[addr_r] <= byte_in; // R11
    end
    REG_RD_DATA <= mem[REG_RD_ADDR];
  end

  // Write notification for the radio core
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WR_PULSE <= 1'b0;
      WR_ADDR  <= `RSL_ADDR_RESET;
      WR_DATA  <= `RSL_BYTE_RESET;
    end else begin
      WR_PULSE <= do_write;
      if (do_write) begin
        WR_ADDR <= addr_r;
        WR_DATA <= byte_in;
      end
    end
  end
endmodule : rsl_radio

// ==== test/rsl_link_assertions.sv ====
// Checker on the four-wire link between host and radio ends.
// Assumes polarity 0, phase 0; checks whole bytes within each select.
`timescale 1ns/100ps
module rsl_link_assertions (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic sck,
  input wire logic mosi,
  input wire logic nss_n,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  logic [7:0] rise_r;
  logic [7:0] rise_nxt;
  logic       sck_q_r;

  // Rising clocks counted per select window, cleared while deselected
  assign rise_nxt = nss_n ? 8'h00 : rise_r + {7'h00, sck & ~sck_q_r};

  // Short on purpose: counter and edge memory only
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rise_r  <= 8'h00;
      sck_q_r <= 1'b0;
    end else begin
      rise_r  <= rise_nxt;
      sck_q_r <= sck;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Half periods last 13 cycles at least; 8 is enough to catch a fast clock
  sequence s_hi_hold; sck [*8]; endsequence
  sequence s_lo_hold; !sck [*8]; endsequence

  property p_sck_idle; nss_n |-> !sck; endproperty
  property p_hi_min; $rose(sck) |-> s_hi_hold; endproperty
  property p_lo_min; $fell(sck) && !nss_n |-> s_lo_hold; endproperty
  property p_mosi_hold; sck && $past(sck) |-> $stable(mosi); endproperty
  property p_miso_hold;
    miso_oe && sck && $past(sck) |-> $stable(miso_o);
  endproperty
  property p_release; $rose(nss_n) |-> ##[0:4] !miso_oe; endproperty
  // Radio must let go so the pull-up, not its own drive, sets the level
  property p_pullup; $rose(nss_n) |-> ##4 (miso && !miso_oe); endproperty
  property p_whole;
    $rose(nss_n) |-> (rise_r[2:0] == 3'h0) && (rise_r != 8'h00);
  endproperty

  a_sck_idle: assert property (p_sck_idle)
    else $error("serial clock not low while deselected");
  a_hi_min: assert property (p_hi_min)
    else $error("serial clock high phase too short");
  a_lo_min: assert property (p_lo_min)
    else $error("serial clock low phase too short");
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("host data moved while clock high");
  a_miso_hold: assert property (p_miso_hold)
    else $error("radio data moved while clock high");
  a_release: assert property (p_release)
    else $error("radio kept driving after deselect");
  a_pullup: assert property (p_pullup)
    else $error("released radio line not high");
  a_whole: assert property (p_whole)
    else $error("select window not whole bytes");
endmodule : rsl_link_assertions

// ==== test/tb.sv ====
// Self-checking bench: host and radio ends joined over one rsl_if.
// Inputs change at the falling edge; expectations wait in queues.
`timescale 1ns/100ps
module tb;
  logic        clk, rst_n, ctrl_wr, ctrl_men, ctrl_pen, int_en, multi_m;
  logic        ssel_n, cs_n, tx_wr, rx_rd, rx_valid, busy, tx_empty;
  logic        men, pen, irq, wr_pulse;
  logic [7:0]  clk_rate, tx_data, rx_data, rd_data, wr_data, seed;
  logic [7:0]  mosi_sh;
  logic [6:0]  rd_addr, wr_addr, ra;
  logic [3:0]  flag_clr, flags;
  logic [8:0]  nt;
  logic [14:0] wn;
  logic [8:0]  rxq[$];
  logic [14:0] wrq[$];
  logic [7:0]  mdl[128];
  int          err_total, checks_done, cyc, rx_room;

  rsl_if link ();
  rsl_host u_rsl_host (.CLK(clk), .RST_N(rst_n), .CTRL_WR(ctrl_wr),
    .CTRL_MASTER_EN(ctrl_men), .CTRL_PORT_EN(ctrl_pen), .CLK_PHASE(1'b0),
    .CLK_POL(1'b0), .CLK_RATE(clk_rate), .INT_EN(int_en),
    .MULTI_MASTER(multi_m), .SLAVE_SEL_N(ssel_n), .CHIP_SELECT_N(cs_n),
    .TX_WRITE(tx_wr), .TX_DATA(tx_data), .RX_READ(rx_rd),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .FLAG_CLR(flag_clr),
    .FLAGS(flags), .IRQ(irq), .BUSY(busy), .TX_EMPTY(tx_empty),
    .MASTER_EN(men), .PORT_EN(pen), .LINK(link));
  rsl_radio u_rsl_radio (.CLK(clk), .RST_N(rst_n), .REG_RD_ADDR(rd_addr),
    .REG_RD_DATA(rd_data), .WR_PULSE(wr_pulse), .WR_ADDR(wr_addr),
    .WR_DATA(wr_data), .LINK(link));
  rsl_link_assertions u_rsl_link_assertions (.CLK(clk), .RST_N(rst_n),
    .sck(link.sck), .mosi(link.mosi), .nss_n(link.nss_n),
    .miso_o(link.miso_o), .miso_oe(link.miso_oe), .miso(link.miso));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk8

  task automatic chk15(input logic [14:0] exp, input logic [14:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk15

  task automatic finish_test;
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask : ticks

  // Stall-limited notes: overrun test keeps only what the buffer can hold
  task automatic note(input logic [8:0] v);
    if (rx_room > 0) begin
      rxq.push_back(v);
      rx_room--;
    end
  endtask : note

  task automatic pulse_clr(input logic [3:0] m);
    flag_clr = m;
    ticks(1);
    flag_clr = 4'h0;
    ticks(1);
  endtask : pulse_clr

  // One byte; dup holds the strobe a second cycle to collide
  task automatic send_byte(input logic [7:0] b, input bit dup);
    int n;
    n = 0;
    while (tx_empty !== 1'b1 && n < 400) begin
      n++;
      ticks(1);
    end
    tx_wr = 1'b1;
    tx_data = b;
    ticks(1);
    if (dup) begin
      tx_data = ~b;
      ticks(1);
    end
    tx_wr = 1'b0;
    ticks(1);
    chk8(8'h03, {6'h00, busy, tx_empty});
    n = 0;
    while (flags[0] !== 1'b1 && n < 400) begin
      n++;
      ticks(1);
    end
    chk8(8'h01, {6'h00, busy, flags[0]});
    chk8(b, mosi_sh);
    pulse_clr(4'h1);
  endtask : send_byte

  // Select window: header then n data bytes to successive registers
  task automatic frame(input logic rw, input logic [6:0] a, input int n,
                       input bit dup);
    logic [7:0] d;
    logic [6:0] ai;
    cs_n = 1'b0;
    ticks(2);
    note(9'h100);
    send_byte({rw, a}, 1'b0);
    for (int i = 0; i < n; i++) begin
      ai = a + i[6:0];
      seed = lfsr(seed);
      d = seed;
      if (rw) begin
        mdl[ai] = d;
        wrq.push_back({ai, d});
        note(9'h100);
      end else begin
        note({1'b0, mdl[ai]});
      end
      send_byte(d, dup);
    end
    ticks(4);
    cs_n = 1'b1;
    ticks(6);
  endtask : frame

  // Wire capture of host data at each rising serial clock
  always @(posedge link.sck) begin
    mosi_sh <= {mosi_sh[6:0], link.mosi};
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Result watcher: oldest note against each popped byte or radio write
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_rd === 1'b1) begin
      nt = 9'h0xx;
      if (rxq.size() > 0) nt = rxq.pop_front();
      if (!nt[8]) chk8(nt[7:0], rx_data);
    end
    if (wr_pulse === 1'b1) begin
      wn = 'x;
      if (wrq.size() > 0) wn = wrq.pop_front();
      chk15(wn, {wr_addr, wr_data});
    end
    cyc++;
    if (cyc > 30000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    {rst_n, ctrl_wr, ctrl_men, ctrl_pen, int_en, multi_m, tx_wr} = '0;
    {ssel_n, cs_n, rx_rd} = 3'h7;
    {tx_data, mosi_sh, rd_addr, flag_clr} = '0;
    clk_rate = 8'h0c;
    seed = 8'h43;
    rx_room = 1000;
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    ticks(4);
    rst_n = 1'b1;
    chk8(8'h00, {3'h0, busy, flags});
    ctrl_wr = 1'b1;
    {ctrl_men, ctrl_pen} = 2'h3;
    ticks(1);
    ctrl_wr = 1'b0;
    ticks(1);
    chk8(8'h03, {6'h00, men, pen});
    frame(1'b1, 7'h7e, 3, 1'b0);
    frame(1'b0, 7'h7e, 3, 1'b0);
    clk_rate = 8'h10;
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      ra = seed[6:0];
      frame(1'b1, ra, 2, 1'b0);
      frame(1'b0, ra, 2, 1'b0);
    end
    rd_addr = 7'h7f;
    ticks(2);
    chk8(mdl[7'h7f], rd_data);
    int_en = 1'b1;
    frame(1'b1, 7'h10, 1, 1'b1);
    chk8(8'h03, {6'h00, irq, flags[1]});
    pulse_clr(4'hf);
    chk8(8'h00, {3'h0, irq, flags});
    rx_rd = 1'b0;
    rx_room = 2;
    frame(1'b0, 7'h7e, 2, 1'b0);
    chk8(8'h01, {7'h00, flags[3]});
    rx_room = 1000;
    rx_rd = 1'b1;
    ticks(4);
    chk8(8'h00, {7'h00, rx_valid});
    pulse_clr(4'hf);
    multi_m = 1'b1;
    ssel_n = 1'b0;
    ticks(5);
    chk8(8'h04, {2'h0, men, pen, flags});
    finish_test();
  end
endmodule : tb
